//--- core/dcis_top.sv
// Purpose: CRC configuration fields and per-channel interrupt summary of a DMA controller
// Assumes: flags, enables and beats come from logic on pclk; APB slave with no wait states
// Notes: one event irq output gated by a mask register
// Summary of operation
// R01: poly field bits 3:2; 0 is CCITT-16, 1 is IEEE-32, 2-3 reserved.
// R02: beat width bits 1:0; 0 is 8, 1 is 16, 2 is 32 bits, 3 reserved.
// R03: beat width shapes CRC data only when the I/O interface is the source.
// R04: read-only summary holds one pending bit per channel 31..0.
// R05: summary bit clears once channel enables or flags are all clear.
// R06: source codes 0x2A..0x3F select channels 10..31, one per code.
// R07: software sets source, polynomial and beat width before enabling CRC.
// R08: writes to the summary register are ignored.
`timescale 1ns/1ns
`include "dcis_defs.svh"
module dcis_top #(
  parameter int NCH = 32,
  parameter int NFLAG = 3,
  parameter logic [5:0] IO_SRC_CODE = `DCIS_SRC_IO
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCIS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel interrupt flags and enables
  input wire logic [NCH*NFLAG-1:0] chan_flags,
  input wire logic [NCH*NFLAG-1:0] chan_enables,
  // CRC beat path
  input wire logic crc_beat_valid,
  input wire logic [31:0] crc_beat_data,
  output logic crc_data_valid,
  output logic [31:0] crc_data,
  // CRC setup seen by the engine
  output logic [31:0] crc_poly_value,
  output logic crc_src_is_io,
  output logic crc_src_is_chan,
  output logic [4:0] crc_src_chan,
  // Interrupt
  output logic irq
);

  logic [31:0] crc_config;
  logic [NCH-1:0] channel_irq_pending;
  logic [31:0] channel_irq_summary;
  logic [`DCIS_EVT_W-1:0] evt_status;
  logic [`DCIS_EVT_W-1:0] evt_mask;
  logic [`DCIS_EVT_W-1:0] evt_set;
  logic setup_ph;
  logic wr_acc;
  logic addr_ok;
  logic [31:0] next_rdata;
  dcis_pkg::dcis_beat_type crc_io_beat_width;
  dcis_pkg::dcis_poly_type crc_poly_select;
  logic [5:0] crc_input_select;
  logic [31:0] beat_mask;

  assign setup_ph = psel & ~penable;
  // No wait states: every access phase completes in its first cycle
  assign pready = psel & penable;
  assign wr_acc = psel & penable & pwrite & clk_en;
  assign addr_ok = (paddr == `DCIS_OFF_CRC_CONFIG) | (paddr == `DCIS_OFF_IRQ_SUMMARY) |
                   (paddr == `DCIS_OFF_EVT_STATUS) | (paddr == `DCIS_OFF_EVT_MASK);
  // Unmapped addresses answer with an error but never stall the bus
  assign pslverr = pready & ~addr_ok;

  assign crc_io_beat_width = dcis_pkg::dcis_beat_type'(crc_config[`DCIS_BEAT_MSB:`DCIS_BEAT_LSB]); // R02
  assign crc_poly_select = dcis_pkg::dcis_poly_type'(crc_config[`DCIS_POLY_MSB:`DCIS_POLY_LSB]); // R01
  assign crc_input_select = crc_config[`DCIS_SRC_MSB:`DCIS_SRC_LSB];

  // Per-channel pending: any flag with its enable; clears as soon as either side clears
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pend
      dcis_chan_pend #(
        .NFLAG(NFLAG)
      ) u_pend (
        .flags(chan_flags[g*NFLAG +: NFLAG]),
        .enables(chan_enables[g*NFLAG +: NFLAG]),
        .pending(channel_irq_pending[g])
      ); // R04 R05
    end
  endgenerate

  // Registered summary; bus writes never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq_summary <= `DCIS_RST_WORD;
    end else if (clk_en) begin
      channel_irq_summary <= 32'(channel_irq_pending); // R04 R05 R08
    end
  end

  // Config register; engine is expected to be off while this changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_config <= `DCIS_RST_WORD;
    end else if (wr_acc && paddr == `DCIS_OFF_CRC_CONFIG) begin
      crc_config <= pwdata & `DCIS_CFG_MASK; // R01 R02 R07
    end
  end

  // Mask has the status layout; irq stays a plain level, no edge logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= '0;
    end else if (wr_acc && paddr == `DCIS_OFF_EVT_MASK) begin
      evt_mask <= pwdata[`DCIS_EVT_W-1:0];
    end
  end

  // Events: a channel newly pending; a reserved poly or beat code written
  always_comb begin
    evt_set = '0;
    evt_set[`DCIS_EVT_NEW_PEND] = |(32'(channel_irq_pending) & ~channel_irq_summary);
    evt_set[`DCIS_EVT_BAD_CODE] = wr_acc && paddr == `DCIS_OFF_CRC_CONFIG &&
      (pwdata[`DCIS_POLY_MSB] || (&pwdata[`DCIS_BEAT_MSB:`DCIS_BEAT_LSB]));
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= '0;
    end else if (clk_en) begin
      if (wr_acc && paddr == `DCIS_OFF_EVT_STATUS) begin
        evt_status <= (evt_status & ~pwdata[`DCIS_EVT_W-1:0]) | evt_set;
      end else begin
        evt_status <= evt_status | evt_set;
      end
    end
  end

  assign irq = |(evt_status & evt_mask);

  // Unmapped offsets read as zero next to the error response
  always_comb begin
    case (paddr)
      `DCIS_OFF_CRC_CONFIG: next_rdata = crc_config;
      `DCIS_OFF_IRQ_SUMMARY: next_rdata = channel_irq_summary; // R04
      `DCIS_OFF_EVT_STATUS: next_rdata = 32'(evt_status);
      `DCIS_OFF_EVT_MASK: next_rdata = 32'(evt_mask);
      default: next_rdata = `DCIS_RST_WORD;
    endcase
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `DCIS_RST_WORD;
    end else if (clk_en && setup_ph) begin
      prdata <= pwrite ? `DCIS_RST_WORD : next_rdata;
    end
  end

  // Source decode: codes past the channel base count channels upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_src_is_io <= 1'b0;
      crc_src_is_chan <= 1'b0;
      crc_src_chan <= '0;
      crc_poly_value <= `DCIS_RST_WORD;
    end else if (clk_en) begin
      crc_src_is_io <= crc_input_select == IO_SRC_CODE;
      crc_src_is_chan <= crc_input_select >= `DCIS_SRC_CH_FIRST &&
                         crc_input_select <= `DCIS_SRC_CH_LAST; // R06
      crc_src_chan <= 5'(crc_input_select - `DCIS_SRC_CH_FIRST) + `DCIS_CH_FIRST; // R06
      case (crc_poly_select)
        dcis_pkg::ccitt16_poly: crc_poly_value <= `DCIS_POLY16; // R01
        dcis_pkg::ieee32_poly: crc_poly_value <= `DCIS_POLY32; // R01
        default: crc_poly_value <= `DCIS_RST_WORD;
      endcase
    end
  end

  always_comb begin
    case (crc_io_beat_width)
      dcis_pkg::byte_beat: beat_mask = `DCIS_BYTE_MASK; // R02
      dcis_pkg::half_word_beat: beat_mask = `DCIS_HALF_MASK; // R02
      dcis_pkg::word_beat: beat_mask = `DCIS_WORD_MASK; // R02
      default: beat_mask = `DCIS_RST_WORD;
    endcase
  end

  // Beat width only shapes I/O-sourced data; reserved width drops I/O beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_data_valid <= 1'b0;
      crc_data <= `DCIS_RST_WORD;
    end else if (clk_en) begin
      if (crc_src_is_io) begin
        crc_data_valid <= crc_beat_valid && crc_io_beat_width != dcis_pkg::reserved_beat; // R03
        crc_data <= crc_beat_data & beat_mask; // R03
      end else begin
        crc_data_valid <= crc_beat_valid && crc_src_is_chan; // R03
        crc_data <= crc_beat_data; // R03
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Summary register: one cycle behind pending, and the bus never writes it
  summary_track_a: assert property (clk_en |=> channel_irq_summary == 32'($past(channel_irq_pending))) // R04
    else $error("summary does not follow pending");
  summary_clear_a: assert property (clk_en && chan_enables == '0 |=> channel_irq_summary == '0) // R05
    else $error("summary not cleared with enables off");
  summary_write_a: assert property (wr_acc && paddr == `DCIS_OFF_IRQ_SUMMARY // R08
    |=> channel_irq_summary == 32'($past(channel_irq_pending)))
    else $error("summary changed by a write");
  summary_read_a: assert property (clk_en && setup_ph && !pwrite && paddr == `DCIS_OFF_IRQ_SUMMARY // R04
    |=> prdata == $past(channel_irq_summary))
    else $error("summary read data wrong");

  // Polynomial decode; reserved codes give no polynomial at all
  poly_select_a: assert property (clk_en && crc_poly_select == dcis_pkg::ieee32_poly // R01
    |=> crc_poly_value == `DCIS_POLY32)
    else $error("ieee32 polynomial not selected");
  poly_ccitt_a: assert property (clk_en && crc_poly_select == dcis_pkg::ccitt16_poly // R01
    |=> crc_poly_value == `DCIS_POLY16)
    else $error("ccitt16 polynomial not selected");
  poly_rsvd_a: assert property (clk_en && crc_config[`DCIS_POLY_MSB] // R01
    |=> crc_poly_value == `DCIS_RST_WORD)
    else $error("reserved polynomial code gave a polynomial");

  // Beat shaping: I/O source masked, channel source whole, no beat out without one in
  beat_byte_a: assert property (clk_en && crc_src_is_io && crc_io_beat_width == dcis_pkg::byte_beat // R02
    |=> (crc_data & ~`DCIS_BYTE_MASK) == '0)
    else $error("byte beat not masked");
  beat_half_a: assert property (clk_en && crc_src_is_io && crc_io_beat_width == dcis_pkg::half_word_beat // R02
    |=> (crc_data & ~`DCIS_HALF_MASK) == '0)
    else $error("half word beat not masked");
  beat_word_a: assert property (clk_en && crc_src_is_io && crc_io_beat_width == dcis_pkg::word_beat // R02
    && crc_beat_valid |=> crc_data_valid && crc_data == $past(crc_beat_data))
    else $error("word beat altered");
  io_rsvd_drop_a: assert property (clk_en && crc_src_is_io && crc_io_beat_width == dcis_pkg::reserved_beat // R03
    |=> !crc_data_valid)
    else $error("beat passed with reserved width");
  chan_full_a: assert property (clk_en && crc_src_is_chan && !crc_src_is_io && crc_beat_valid // R03
    |=> crc_data_valid && crc_data == $past(crc_beat_data))
    else $error("channel beat altered by width");
  beat_none_a: assert property (clk_en && !crc_beat_valid |=> !crc_data_valid) // R03
    else $error("beat out without a beat in");

  // Source decode: I/O code, channel range and its end points
  io_decode_a: assert property (clk_en && crc_input_select == IO_SRC_CODE // R03
    |=> crc_src_is_io && !crc_src_is_chan)
    else $error("io source code not decoded");
  chan_first_a: assert property (clk_en && crc_input_select == `DCIS_SRC_CH_FIRST // R06
    |=> crc_src_is_chan && crc_src_chan == `DCIS_CH_FIRST)
    else $error("first source code not channel 10");
  chan_map_a: assert property (clk_en && crc_input_select == `DCIS_SRC_CH_LAST // R06
    |=> crc_src_is_chan && crc_src_chan == `DCIS_CH_LAST)
    else $error("last source code not channel 31");
  src_below_a: assert property (clk_en && crc_input_select < `DCIS_SRC_CH_FIRST // R06
    |=> !crc_src_is_chan)
    else $error("code below channel range taken as channel");

  // Register writes and the event flags
  cfg_write_a: assert property (wr_acc && paddr == `DCIS_OFF_CRC_CONFIG // R07
    |=> crc_config == ($past(pwdata) & `DCIS_CFG_MASK))
    else $error("config write lost");
  cfg_hold_a: assert property (!(wr_acc && paddr == `DCIS_OFF_CRC_CONFIG) |=> $stable(crc_config)) // R07
    else $error("config changed without a write");
  mask_write_a: assert property (wr_acc && paddr == `DCIS_OFF_EVT_MASK
    |=> evt_mask == $past(pwdata[`DCIS_EVT_W-1:0]))
    else $error("mask write lost");
  evt_sticky_a: assert property (clk_en && evt_set[`DCIS_EVT_NEW_PEND] |=> evt_status[`DCIS_EVT_NEW_PEND])
    else $error("new pending event lost");
  evt_clear_a: assert property (wr_acc && paddr == `DCIS_OFF_EVT_STATUS && pwdata[`DCIS_EVT_NEW_PEND]
    && !evt_set[`DCIS_EVT_NEW_PEND] |=> !evt_status[`DCIS_EVT_NEW_PEND])
    else $error("pending event not cleared by write one");
  bad_code_a: assert property (wr_acc && paddr == `DCIS_OFF_CRC_CONFIG && pwdata[`DCIS_POLY_MSB] // R01
    |=> evt_status[`DCIS_EVT_BAD_CODE])
    else $error("reserved polynomial write not flagged");

  pend_seen_c: cover property (clk_en && channel_irq_summary != '0 ##1 channel_irq_summary == '0);
  io_half_c: cover property (crc_data_valid && crc_src_is_io && crc_io_beat_width == dcis_pkg::half_word_beat);
  chan_src_c: cover property (crc_data_valid && crc_src_is_chan);
  irq_c: cover property (irq);
  bad_code_c: cover property (evt_status[`DCIS_EVT_BAD_CODE]);

endmodule // dcis_top

// One channel's flags reduced to its pending bit; any enabled flag counts
module dcis_chan_pend #(
  parameter int NFLAG = 3
) (
  // Flag state of one channel
  input wire logic [NFLAG-1:0] flags,
  input wire logic [NFLAG-1:0] enables,
  // Pending bit for the summary
  output logic pending
);

  assign pending = |(flags & enables); // R04 R05

endmodule // dcis_chan_pend

//--- pkg/dcis_defs.svh
// Purpose: register offsets, field positions and codes of the CRC config and irq summary block
// Assumes: 32-bit APB, byte addresses
// Notes: definitions only
`ifndef DCIS_DEFS_SVH
`define DCIS_DEFS_SVH
`define DCIS_ADDR_W 8
`define DCIS_OFF_CRC_CONFIG 8'h20
`define DCIS_OFF_IRQ_SUMMARY 8'h24
`define DCIS_OFF_EVT_STATUS 8'h28
`define DCIS_OFF_EVT_MASK 8'h2C
`define DCIS_RST_WORD 32'h00000000
`define DCIS_BEAT_LSB 0
`define DCIS_BEAT_MSB 1
`define DCIS_POLY_LSB 2
`define DCIS_POLY_MSB 3
`define DCIS_SRC_LSB 8
`define DCIS_SRC_MSB 13
`define DCIS_CFG_MASK 32'h00003F0F
`define DCIS_SRC_NONE 6'h00
`define DCIS_SRC_IO 6'h01
`define DCIS_SRC_CH_FIRST 6'h2A
`define DCIS_SRC_CH_LAST 6'h3F
`define DCIS_CH_FIRST 5'h0A
`define DCIS_CH_LAST 5'h1F
`define DCIS_EVT_W 2
`define DCIS_EVT_NEW_PEND 0
`define DCIS_EVT_BAD_CODE 1
`define DCIS_BYTE_MASK 32'h000000FF
`define DCIS_HALF_MASK 32'h0000FFFF
`define DCIS_WORD_MASK 32'hFFFFFFFF
`define DCIS_POLY16 32'h00001021
`define DCIS_POLY32 32'h04C11DB7
`endif

//--- pkg/dcis_pkg.sv
// Purpose: types of the CRC config and irq summary block
// Assumes: encodings follow declaration order
// Notes: none
package dcis_pkg;
  typedef enum logic [1:0] {byte_beat, half_word_beat, word_beat, reserved_beat} dcis_beat_type;
  typedef enum logic [1:0] {ccitt16_poly, ieee32_poly, poly_rsvd2, poly_rsvd3} dcis_poly_type;
endpackage

//--- test/tb_dma_crc_and_irq_status.sv
// Purpose: self-checking bench of the CRC config and irq summary block
// Assumes: APB answers while psel and penable are high; clk_en held high
// Notes: read data and CRC beats are checked against queued expectations
`timescale 1ns/1ns
module tb_dma_crc_and_irq_status;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] crc_beat_data = 32'h0;
  logic crc_beat_valid = 1'b0;
  logic [95:0] chan_flags = '0;
  logic [95:0] chan_enables = '0;
  logic [31:0] prdata, crc_data, crc_poly_value, r;
  logic pready, pslverr, crc_data_valid, crc_src_is_io, crc_src_is_chan, irq;
  logic [4:0] crc_src_chan;
  logic [95:0] f, e;
  logic [32:0] rq[$];
  logic [31:0] cq[$];
  int err_count = 0;
  int compares = 0;
  always #25 pclk = ~pclk;
  dcis_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_flags(chan_flags), .chan_enables(chan_enables), .crc_beat_valid(crc_beat_valid),
    .crc_beat_data(crc_beat_data), .crc_data_valid(crc_data_valid), .crc_data(crc_data),
    .crc_poly_value(crc_poly_value), .crc_src_is_io(crc_src_is_io), .crc_src_is_chan(crc_src_is_chan),
    .crc_src_chan(crc_src_chan), .irq(irq));
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Idle edge at the end keeps psel from being assigned twice in one step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] x);
    rq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task beat(input logic [31:0] d, input logic [31:0] x, input bit push);
    if (push) cq.push_back(x);
    crc_beat_valid <= 1'b1;
    crc_beat_data <= d;
    @(posedge pclk);
    crc_beat_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // Outputs sampled at the falling edge, once every update has landed
  task settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  function automatic logic [31:0] summ(input logic [95:0] fl, input logic [95:0] en);
    for (int n = 0; n < 32; n++) summ[n] = |(fl[n*3+:3] & en[n*3+:3]);
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && rq.size() > 0) chk({pslverr, prdata}, rq.pop_front());
    if (crc_data_valid === 1'b1) chk(crc_data, cq.size() > 0 ? cq.pop_front() : ~crc_data);
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h7AD9E074));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h24, 33'h0);
    rd(8'h20, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    apb(1'b1, 8'h2C, 32'h1);
    apb(1'b1, 8'h28, 32'h3);
    for (int p = 0; p < 4; p++) for (int w = 0; w < 4; w++) begin
      apb(1'b1, 8'h20, {18'h0, 6'h01, 4'h0, p[1:0], w[1:0]});
      rd(8'h20, {1'b0, 18'h0, 6'h01, 4'h0, p[1:0], w[1:0]});
      @(negedge pclk);
      chk(crc_poly_value, p == 0 ? 32'h1021 : p == 1 ? 32'h04C11DB7 : 32'h0);
      chk(crc_src_is_io, 1'b1);
      @(posedge pclk);
      r = $urandom();
      beat(r, w == 0 ? r & 32'hFF : w == 1 ? r & 32'hFFFF : r, w < 3);
    end
    for (int c = 8'h2A; c <= 8'h3F; c++) begin
      apb(1'b1, 8'h20, {18'h0, c[5:0], 8'h00});
      @(negedge pclk);
      chk(crc_src_is_chan, 1'b1);
      chk(crc_src_chan, 64'(c - 8'h20));
      @(posedge pclk);
      r = $urandom();
      beat(r, r, 1'b1);
    end
    apb(1'b1, 8'h20, {18'h0, 6'h29, 8'h00});
    @(negedge pclk);
    chk({crc_src_is_io, crc_src_is_chan}, 2'b00);
    @(posedge pclk);
    beat($urandom(), 32'h0, 1'b0);
    apb(1'b1, 8'h28, 32'h3);
    f = {$urandom(), $urandom(), $urandom()};
    e = {$urandom(), $urandom(), $urandom()};
    chan_flags <= f;
    chan_enables <= e;
    settle();
    chk(irq, |summ(f, e));
    @(posedge pclk);
    rd(8'h24, {1'b0, summ(f, e)});
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    rd(8'h24, {1'b0, summ(f, e)});
    apb(1'b1, 8'h28, 32'h1);
    settle();
    chk(irq, 1'b0);
    @(posedge pclk);
    chan_enables <= '0;
    settle();
    @(posedge pclk);
    rd(8'h24, 33'h0);
    apb(1'b1, 8'h2C, 32'h0);
    chan_enables <= e;
    settle();
    chk(irq, 1'b0);
    @(posedge pclk);
    rd(8'h28, {32'h0, |summ(f, e)});
    chan_flags <= '0;
    settle();
    @(posedge pclk);
    rd(8'h24, 33'h0);
    apb(1'b1, 8'h2C, 32'h1);
    settle();
    chk(irq, |summ(f, e));
    chk(rq.size(), 0);
    chk(cq.size(), 0);
    results();
  end
endmodule // tb_dma_crc_and_irq_status
